/* File: usb_frame_scratch_test_regs.sv */
`timescale 1ns/10ps
module usb_frame_scratch_test_regs (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        bus_reset,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic        byte_mode,
  output logic      [15:0] reg_rdata,
  input  wire logic        sof_strobe,
  input  wire logic        sof_ok,
  input  wire logic [10:0] sof_frame,
  input  wire logic [2:0]  sof_micro,
  output logic             hs_only,
  output logic             fs_only,
  output logic             chirp_detect_en,
  output logic             nak_all_hs_in,
  output logic             line_dp,
  output logic             line_dm,
  output logic             line_oe
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [15:0] scratch_reg;
  logic [7:0]  test_reg;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic        high_byte_reg;
  wire  logic [15:0] frame_value;

  line_test_if lt ();

  sof_capture u_sof (
    .core_clk    (core_clk),
    .nrst        (nrst),
    .ce          (ce),
    .bus_reset   (bus_reset),
    .sof_strobe  (sof_strobe),
    .sof_ok      (sof_ok),
    .sof_frame   (sof_frame),
    .sof_micro   (sof_micro),
    .frame_value (frame_value)
  );

  line_pattern_gen u_gen (
    .core_clk (core_clk),
    .nrst     (nrst),
    .ce       (ce),
    .lt       (lt)
  );

  // ****************************************************************
  // Address decode
  // ****************************************************************
  wire logic sel_frame;
  wire logic sel_scratch;
  wire logic sel_test;
  wire logic wr_scratch;
  wire logic wr_test;
  wire logic rd_frame_byte;

  assign sel_frame     = reg_addr == usb_regs_pkg::frame_counter_addr;
  assign sel_scratch   = reg_addr == usb_regs_pkg::firmware_scratch_addr;
  assign sel_test      = reg_addr == usb_regs_pkg::line_test_control_addr;
  assign wr_scratch    = reg_wr & sel_scratch;
  assign wr_test       = reg_wr & sel_test;
  assign rd_frame_byte = reg_rd & sel_frame & byte_mode;

  // ****************************************************************
  // Writable registers
  // ****************************************************************
  // Scratch keeps firmware data; nothing in hardware looks at it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      scratch_reg <= usb_regs_pkg::firmware_scratch_rst;
    end else if (ce) begin
      if (bus_reset) begin
        scratch_reg <= usb_regs_pkg::firmware_scratch_rst;
      end else if (wr_scratch) begin
        scratch_reg <= reg_wdata;
      end
    end
  end

  // Test control; one-hot use is left to firmware, not enforced
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      test_reg <= usb_regs_pkg::line_test_control_rst;
    end else if (ce) begin
      if (bus_reset) begin
        test_reg <= usb_regs_pkg::line_test_control_rst;
      end else if (wr_test) begin
        test_reg <= reg_wdata[7:0];
      end
    end
  end

  // ****************************************************************
  // Byte sequencing of the frame register
  // ****************************************************************
  // Toggles per byte read so two reads give low then high
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      high_byte_reg <= 1'b0;
    end else if (ce) begin
      if (bus_reset || !byte_mode) begin
        high_byte_reg <= 1'b0;
      end else if (rd_frame_byte) begin
        high_byte_reg <= ~high_byte_reg;
      end
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  wire logic [15:0] frame_word;
  wire logic [15:0] frame_byte;

  assign frame_word = frame_value;
  assign frame_byte = high_byte_reg ? {8'h00, frame_word[15:8]}
                                    : {8'h00, frame_word[7:0]};

  // Unmapped addresses read as zero
  always_comb begin
    rdata_next = 16'h0000;
    if (sel_frame) begin
      rdata_next = byte_mode ? frame_byte : frame_word;
    end else if (sel_scratch) begin
      rdata_next = scratch_reg;
    end else if (sel_test) begin
      rdata_next = {8'h00, test_reg};
    end
  end

  // Data stands for the one cycle after the read strobe only
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 16'h0000;
    end else if (ce) begin
      rdata_reg <= reg_rd ? rdata_next : 16'h0000;
    end
  end

  assign reg_rdata = rdata_reg;

  // ****************************************************************
  // Speed and line control
  // ****************************************************************
  wire logic force_hs;
  wire logic force_fs;

  assign force_hs = test_reg[usb_regs_pkg::force_high_speed_bit];
  assign force_fs = test_reg[usb_regs_pkg::force_full_speed_bit];

  // Either forcing bit stops chirp; clear bits give normal negotiation
  assign hs_only         = force_hs;
  assign fs_only         = force_fs;
  assign chirp_detect_en = ~(force_hs | force_fs);

  assign lt.random_en = test_reg[usb_regs_pkg::random_pattern_test_bit];
  assign lt.k_en      = test_reg[usb_regs_pkg::drive_k_test_bit];
  assign lt.j_en      = test_reg[usb_regs_pkg::drive_j_test_bit];
  assign lt.quiet_en  = test_reg[usb_regs_pkg::quiet_nak_test_bit];

  // Engine must answer every high-speed IN with NAK while set
  assign nak_all_hs_in = lt.quiet_en;

  assign line_dp = lt.dp;
  assign line_dm = lt.dm;
  assign line_oe = lt.oe;
endmodule

/* File: usb_regs_pkg.sv */
// Summary of operation
// - Latch frame bits 10:0 and microframe bits 13:11 of last good SOF.
// - In byte mode the frame register reads low byte, then high byte.
// - Sixteen-bit scratch register, read and write, no side effects.
// - Test bit 7 forces high speed only and disables chirp detection.
// - Test bit 4 forces full speed only and disables chirp detection.
// - Test bit 3 toggles the data lines in a fixed pseudo-random pattern.
// - Test bit 2 drives the data line pair steadily to K.
// - Test bit 1 drives the data line pair steadily to J.
// - Test bit 0 holds quiescent lines and answers high-speed IN with NAK.
package usb_regs_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0]  frame_counter_addr     = 8'h74;
  localparam logic [7:0]  firmware_scratch_addr  = 8'h78;
  localparam logic [7:0]  line_test_control_addr = 8'h84;

  localparam logic [15:0] frame_counter_rst      = 16'h0000;
  localparam logic [15:0] firmware_scratch_rst   = 16'h0000;
  localparam logic [7:0]  line_test_control_rst  = 8'h00;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int frame_index_lsb      = 0;
  localparam int frame_index_w        = 11;
  localparam int microframe_index_lsb = 11;
  localparam int microframe_index_w   = 3;

  localparam int force_high_speed_bit    = 7;
  localparam int force_full_speed_bit    = 4;
  localparam int random_pattern_test_bit = 3;
  localparam int drive_k_test_bit        = 2;
  localparam int drive_j_test_bit        = 1;
  localparam int quiet_nak_test_bit      = 0;

  // ****************************************************************
  // Pattern generator
  // ****************************************************************
  localparam int          random_pattern_test_w    = 15;
  localparam logic [14:0] random_pattern_test_seed = 15'h7fff;

endpackage

/* File: line_test_if.sv */
`timescale 1ns/10ps
// Line test requests out, line drive values back
interface line_test_if;
  logic random_en;
  logic k_en;
  logic j_en;
  logic quiet_en;
  logic dp;
  logic dm;
  logic oe;

  modport ctrl (output random_en, k_en, j_en, quiet_en,
                input dp, dm, oe);
  modport gen  (input random_en, k_en, j_en, quiet_en,
                output dp, dm, oe);
endinterface

/* File: sof_capture.sv */
`timescale 1ns/10ps
module sof_capture (
  input  wire logic        core_clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        bus_reset,
  input  wire logic        sof_strobe,
  input  wire logic        sof_ok,
  input  wire logic [10:0] sof_frame,
  input  wire logic [2:0]  sof_micro,
  output logic      [15:0] frame_value
);

  logic [15:0] frame_reg;
  wire  logic  take_sof;
  wire  logic [15:0] frame_next;

  // Only an error-free SOF may overwrite the last good number
  assign take_sof   = sof_strobe & sof_ok;
  assign frame_next = {2'b00, sof_micro, sof_frame};

  // Capture, cleared by power-on and bus reset
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      frame_reg <= usb_regs_pkg::frame_counter_rst;
    end else if (ce) begin
      if (bus_reset) begin
        frame_reg <= usb_regs_pkg::frame_counter_rst;
      end else if (take_sof) begin
        frame_reg <= frame_next;
      end
    end
  end

  assign frame_value = frame_reg;
endmodule

/* File: line_pattern_gen.sv */
`timescale 1ns/10ps
module line_pattern_gen (
  input  wire logic  core_clk,
  input  wire logic  nrst,
  input  wire logic  ce,
  line_test_if.gen   lt
);

  localparam int w = usb_regs_pkg::random_pattern_test_w;

  logic [w-1:0] lfsr_reg;
  logic [w-1:0] lfsr_next;
  logic         dp_reg;
  logic         dm_reg;
  logic         oe_reg;
  wire  logic   fb;

  // Taps 15 and 14: maximal length, so the pattern repeats exactly
  assign fb = lfsr_reg[w-1] ^ lfsr_reg[w-2];

  genvar i;
  generate
    for (i = 1; i < w; i++) begin : g_shift
      assign lfsr_next[i] = lfsr_reg[i-1];
    end
  endgenerate
  assign lfsr_next[0] = fb;

  // Pattern restarts from the seed whenever the test is off
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lfsr_reg <= usb_regs_pkg::random_pattern_test_seed;
    end else if (ce) begin
      if (lt.random_en) begin
        lfsr_reg <= lfsr_next;
      end else begin
        lfsr_reg <= usb_regs_pkg::random_pattern_test_seed;
      end
    end
  end

  // Line drive; priority only matters if firmware breaks one-hot use
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      dp_reg <= 1'b0;
      dm_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else if (ce) begin
      if (lt.random_en) begin
        dp_reg <= lfsr_reg[w-1];
        dm_reg <= ~lfsr_reg[w-1];
        oe_reg <= 1'b1;
      end else if (lt.k_en) begin
        dp_reg <= 1'b0;
        dm_reg <= 1'b1;
        oe_reg <= 1'b1;
      end else if (lt.j_en) begin
        dp_reg <= 1'b1;
        dm_reg <= 1'b0;
        oe_reg <= 1'b1;
      end else if (lt.quiet_en) begin
        dp_reg <= 1'b0;
        dm_reg <= 1'b0;
        oe_reg <= 1'b1;
      end else begin
        dp_reg <= 1'b0;
        dm_reg <= 1'b0;
        oe_reg <= 1'b0;
      end
    end
  end

  assign lt.dp = dp_reg;
  assign lt.dm = dm_reg;
  assign lt.oe = oe_reg;
endmodule

/* File: sof_host_model.sv */
`timescale 1ns/10ps
// ****
// Host side SOF source
// ****
module sof_host_model (
  input  wire logic        core_clk,
  input  wire logic        send,
  input  wire logic        good,
  input  wire logic [13:0] num,
  output logic             sof_strobe,
  output logic             sof_ok,
  output logic      [10:0] sof_frame,
  output logic      [2:0]  sof_micro
);
  logic [14:0] last_reg = 15'h0000;
  // Remember the last token so idle lines can show its inverse
  always_ff @(posedge core_clk) begin
    if (send) begin
      last_reg <= {good, num};
    end
  end
  // Idle lines never hold old numbers: a stale match would hide faults
  assign sof_strobe = send;
  assign {sof_ok, sof_micro, sof_frame} = send ? {good, num} : ~last_reg;
endmodule

/* File: usb_regs_monitor.sv */
`timescale 1ns/10ps
// ****
// Port checks
// ****
module usb_regs_monitor (
  input wire logic        core_clk,
  input wire logic        nrst,
  input wire logic        ce,
  input wire logic        bus_reset,
  input wire logic [7:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic        byte_mode,
  input wire logic [15:0] reg_rdata,
  input wire logic        sof_strobe,
  input wire logic        sof_ok,
  input wire logic [10:0] sof_frame,
  input wire logic [2:0]  sof_micro,
  input wire logic        hs_only,
  input wire logic        fs_only,
  input wire logic        chirp_detect_en,
  input wire logic        nak_all_hs_in,
  input wire logic        line_dp,
  input wire logic        line_dm,
  input wire logic        line_oe
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  // Qualified events; a bus reset voids any expectation
  wire live = ce && !bus_reset;
  wire sof_in = live && sof_strobe && sof_ok;
  wire calm = live && !sof_strobe;
  wire frd = calm && reg_rd && reg_addr == 8'h74;
  wire twr = live && reg_wr && reg_addr == 8'h84;
  wire hold = live && !twr;
  wire [7:0] tv = reg_wdata[7:0];
  frame_word_a: assert property (
    sof_in ##1 calm ##1 frd && !byte_mode |=>
    reg_rdata == {2'b00, $past(sof_micro, 3), $past(sof_frame, 3)})
    else $error("frame word wrong");
  frame_low_a: assert property (
    sof_in && !byte_mode ##1 calm && !byte_mode ##1 frd && byte_mode
    |=> reg_rdata[7:0] == $past(sof_frame[7:0], 3))
    else $error("frame low byte wrong");
  scratch_rw_a: assert property (
    live && reg_wr && reg_addr == 8'h78 ##1 live && reg_rd &&
    reg_addr == 8'h78 |=> reg_rdata == $past(reg_wdata, 2))
    else $error("scratch readback wrong");
  force_hs_a: assert property (twr |=> hs_only == $past(tv[7]))
    else $error("high speed force wrong");
  force_fs_a: assert property (twr |=> fs_only == $past(tv[4]))
    else $error("full speed force wrong");
  chirp_off_a: assert property (
    chirp_detect_en == !(hs_only || fs_only))
    else $error("chirp enable wrong");
  nak_mode_a: assert property (
    twr |=> nak_all_hs_in == $past(tv[0]))
    else $error("nak mode wrong");
  random_line_a: assert property (
    twr && tv[3] ##1 hold[*2] |-> line_oe && line_dp != line_dm)
    else $error("random pattern not driven");
  k_line_a: assert property (
    twr && tv[3:0] == 4'h4 ##1 hold[*2] |-> line_oe && !line_dp && line_dm)
    else $error("K state wrong");
  j_line_a: assert property (
    twr && tv[3:0] == 4'h2 ##1 hold[*2] |-> line_oe && line_dp && !line_dm)
    else $error("J state wrong");
  quiet_line_a: assert property (
    twr && tv[3:0] == 4'h1 ##1 hold[*2] |-> line_oe && !line_dp && !line_dm)
    else $error("quiescent state wrong");
  lines_free_a: assert property (
    twr && tv[3:0] == 4'h0 ##1 hold[*2] |-> !line_oe)
    else $error("lines driven outside test");
endmodule
bind usb_frame_scratch_test_regs usb_regs_monitor mon_u (.*);

/* File: usb_frame_scratch_test_regs_tb.sv */
`timescale 1ns/10ps
// ****
// Register bank bench
// ****
module usb_frame_scratch_test_regs_tb;
  logic        ce, core_clk, nrst, bus_reset, reg_wr, reg_rd, byte_mode;
  logic        send, good, pend, seen, d0, sof_strobe, sof_ok;
  logic        hs_only, fs_only, chirp_detect_en, nak_all_hs_in;
  logic        line_dp, line_dm, line_oe;
  logic [7:0]  reg_addr, tcode;
  logic [15:0] reg_wdata, reg_rdata, rexp, rmsk, pexp, pmsk;
  logic [13:0] num;
  logic [10:0] sof_frame;
  logic [2:0]  sof_micro;
  logic [7:0]  codes [7] = '{8'h80, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h00};
  int          n_mismatch, checks_done, cyc, scr, tst, frm, ptr, bm, k;
  integer      seed;
  usb_frame_scratch_test_regs dut_u (.*);
  sof_host_model host_u (.*);
  always #25 core_clk = ~core_clk;
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One bus cycle; strobes are rewritten by the next call, never twice
  task automatic bus(input logic w, r, s, input logic [7:0] a,
                     input logic [15:0] d);
    if (bm == 0) ptr = 0;
    reg_wr <= w;
    reg_rd <= r;
    send <= s;
    reg_addr <= a;
    reg_wdata <= d;
    byte_mode <= bm[0];
    @(posedge core_clk);
  endtask
  task automatic idle();
    bus(0, 0, 0, 8'h00, 16'h0000);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    if (a == 8'h78) scr = d;
    if (a == 8'h84) tst = d[7:0];
    bus(1, 0, 0, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    int e;
    e = a == 8'h74 ? frm : a == 8'h78 ? scr : a == 8'h84 ? tst : 0;
    rmsk <= (a == 8'h74 && bm) ? 16'h00ff : 16'hffff;
    if (a == 8'h74 && bm) begin
      e = ptr ? frm >> 8 : frm & 255;
      ptr ^= 1;
    end
    rexp <= 16'(e);
    bus(0, 1, 0, a, 16'h0000);
  endtask
  task automatic sof(input logic [13:0] n, input logic g);
    if (g) frm = n;
    num <= n;
    good <= g;
    bus(0, 0, 1, 8'h00, 16'h0000);
  endtask
  // Line state check; pattern bits are unknown, so only their relation
  task automatic lines();
    cmp({hs_only, fs_only, chirp_detect_en, nak_all_hs_in, line_oe,
         tst[3] ? line_dp ^ line_dm : line_dp & line_oe,
         line_dm & line_oe & !tst[3]},
        {tst[7], tst[4], !(tst[7] | tst[4]), tst[0], |tst[3:0],
         tst[3] | (!tst[2] & tst[1]), !tst[3] & tst[2]});
  endtask
  // Read data compared at the falling edge, once the register has settled
  always @(negedge core_clk) begin
    if (nrst) begin
      cmp(reg_rdata & pmsk, pend ? pexp : 16'h0000);
    end
  end
  // Read data due one cycle after each read, zero otherwise; watchdog
  always @(posedge core_clk) begin
    pend <= reg_rd;
    pexp <= rexp;
    pmsk <= reg_rd ? rmsk : 16'hffff;
    cyc++;
    if (cyc == 5000) begin
      n_mismatch++;
      summarize();
    end
  end
  initial begin
    seed = 32'h9daf25fc;
    {ce, core_clk, nrst, bus_reset, reg_wr, reg_rd, byte_mode} = 7'h40;
    {send, good, pend, reg_addr, reg_wdata, num} = 41'h000_0000_0000;
    {rexp, rmsk} = 32'h0000_ffff;
    repeat (12) @(posedge core_clk);
    nrst <= 1;
    for (k = 0; k < 3; k++) rd(codes[k] == 8'h80 ? 8'h74 : 8'h78 + k[7:0]);
    rd(8'h84);
    // Scratch words written and read back to back
    for (k = 0; k < 8; k++) begin
      wr(8'h78, 16'($random(seed)));
      rd(8'h78);
    end
    // Unmapped place and read-only frame register are left alone
    wr(8'h90, 16'h5a5a);
    wr(8'h74, 16'h3fff);
    rd(8'h90);
    rd(8'h74);
    rd(8'h78);
    // Good and bad SOF; word read, then byte reads low before high
    for (k = 0; k < 4; k++) begin
      sof(14'($random(seed)), k != 2);
      idle();
      rd(8'h74);
      sof(14'($random(seed)), 1'b1);
      idle();
      bm = 1;
      rd(8'h74);
      rd(8'h74);
      bm = 0;
    end
    // One code at a time, spare bits 6:5 random
    for (k = 0; k < 7; k++) begin
      tcode = codes[k] | (8'($random(seed)) & 8'h60);
      wr(8'h84, {8'h00, tcode});
      idle();
      idle();
      lines();
      seen = 0;
      d0 = line_dp;
      repeat (16) begin
        idle();
        seen |= line_dp !== d0;
      end
      if (k == 2) cmp(16'(seen), 16'h0001);
      rd(8'h84);
    end
    // Clock enable low: writes are lost and the K state holds
    wr(8'h84, 16'h0004);
    idle();
    ce <= 1'b0;
    repeat (4) begin
      bus(1, 0, 0, 8'h84, 16'h0000);
      bus(1, 0, 0, 8'h78, ~16'(scr));
    end
    ce <= 1'b1;
    lines();
    rd(8'h78);
    rd(8'h84);
    // Bus reset clears every register
    wr(8'h78, 16'hffff);
    wr(8'h84, 16'h0004);
    bus_reset <= 1;
    idle();
    bus_reset <= 0;
    {scr, tst, frm} = 96'h0;
    idle();
    idle();
    lines();
    rd(8'h74);
    rd(8'h78);
    rd(8'h84);
    idle();
    idle();
    summarize();
  end
endmodule
